// ==== verilog/pport_pkg.sv ====
// Behaviour
// - master holds address, asserts chip select first
// - output enable starts driving the data bus
// - read strobe puts addressed FIFO word out; code does so at address zero only, others give an address/pointer pattern
// - read pointer advances on strobe release
// - master keeps output enable during reads
// - strobe and output enable may be tied
// - burst: old FIFO data until ready asserts
// - muxed reads repeat under held chip enable
// - muxed read ends at first OE/CE release
// - muxed writes repeat under held chip enable
// - muxed write ends at first WE/CE release
// - both ends use the same clock edge
// - ready asserts two cycles after OE
// - ready drops one cycle after last word
// - first data two cycles after OE
// - last word held until OE released
// - transfers are whole bursts
// - ready never drops mid-burst
// - master keeps OE through a burst
// - latency selectable two or one cycle
package pport_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 2;
  localparam int BURST_LOG_W = 3;
  localparam logic [1:0] MODE_FIFO = 2'h0;
  localparam logic [1:0] MODE_AMUX = 2'h1;
  localparam logic [1:0] MODE_SYNC = 2'h2;
  localparam logic [1:0] LAT_LONG = 2'h2;
  localparam logic [1:0] LAT_SHORT = 2'h1;
  localparam int LINK_DIV = 25;
endpackage

// ==== verilog/pport_if.sv ====
`timescale 1ns/1ps
interface pport_if;
  logic linkClk;
  logic csN;
  logic oeN;
  logic rdN;
  logic weN;
  logic addressValidN;
  logic [pport_pkg::ADDR_W-1:0] addr;
  logic [pport_pkg::DATA_W-1:0] hostDq;
  logic hostDqOeN;
  logic [pport_pkg::DATA_W-1:0] devDq;
  logic devDqOeN;
  logic ready;
  wire [pport_pkg::DATA_W-1:0] dq = !devDqOeN ? devDq : hostDq;
  modport device(input linkClk, csN, oeN, rdN, weN, addressValidN, addr, hostDq, hostDqOeN,
    output devDq, devDqOeN, ready);
  modport host(output linkClk, csN, oeN, rdN, weN, addressValidN, addr, hostDq, hostDqOeN,
    input devDq, devDqOeN, ready);
endinterface

// ==== verilog/word_fifo.sv ====
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } state_s;
  state_s st_reg, st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full, empty;
  assign empty = st_reg.wp == st_reg.rp;
  assign full = (st_reg.wp[AW-1:0] == st_reg.rp[AW-1:0]) && (st_reg.wp[AW] != st_reg.rp[AW]);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[st_reg.rp[AW-1:0]];
  always_comb begin
    st_next = st_reg;
    if (inValid && !full) st_next.wp = st_reg.wp + 1'b1;
    if (outReady && !empty) st_next.rp = st_reg.rp + 1'b1;
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) st_reg <= '0;
    else st_reg <= st_next;
    if (inValid && !full) mem[st_reg.wp[AW-1:0]] <= inData;
  end
endmodule

// ==== verilog/pport_device.sv ====
`timescale 1ns/1ps
module pport_device #(
  parameter int NFIFO = 4,
  parameter int DATA_W = pport_pkg::DATA_W
) (
  input wire logic mclk,
  input wire logic sys_rst,
  pport_if.device link,
  input wire logic [1:0] mode,
  input wire logic shortLatency,
  input wire logic [pport_pkg::BURST_LOG_W-1:0] burstLog,
  input wire logic [DATA_W-1:0] srcData,
  input wire logic srcValid,
  output logic srcReady,
  output logic [DATA_W-1:0] wrData,
  output logic wrStrobe,
  output logic [NFIFO*4-1:0] fifoPtrs
);
  localparam int AW = pport_pkg::ADDR_W;
  typedef struct packed {
    logic [1:0] s1, s2, s3, s4, s5, s6;
    logic cl1, cl2, cl3;
    logic [AW-1:0] a1, a2;
    logic [DATA_W-1:0] d1, d2;
    logic prevRd, prevWe, prevClk, active;
    logic [DATA_W-1:0] dout;
    logic dOeN;
    logic rdy;
    logic [1:0] lat;
    logic [8:0] left;
    logic [NFIFO*4-1:0] ptrs;
    logic [DATA_W-1:0] wd;
    logic ws;
  } state_s;
  state_s st_reg, st_next;
  logic csN, oeN, rdN, weN, clkS, rise;
  logic fifoValid, pop;
  logic [DATA_W-1:0] fifoData;
  word_fifo #(.WIDTH(DATA_W), .DEPTH(4)) u_fifo (.mclk(mclk), .sys_rst(sys_rst),
    .inValid(srcValid), .inReady(srcReady), .inData(srcData), .outValid(fifoValid),
    .outReady(pop), .outData(fifoData));
  assign csN = st_reg.s2[0];
  assign oeN = st_reg.s2[1];
  assign rdN = st_reg.s4[0];
  assign weN = st_reg.s4[1];
  assign clkS = st_reg.cl2;
  assign rise = clkS && !st_reg.prevClk;
  assign link.devDq = st_reg.dout;
  assign link.devDqOeN = st_reg.dOeN;
  assign link.ready = st_reg.rdy;
  assign wrData = st_reg.wd;
  assign wrStrobe = st_reg.ws;
  assign fifoPtrs = st_reg.ptrs;
  always_comb begin
    st_next = st_reg;
    pop = 1'b0;
    st_next.s1 = {link.oeN, link.csN};
    st_next.s2 = st_reg.s1;
    st_next.s3 = {link.weN, link.rdN};
    st_next.s4 = st_reg.s3;
    st_next.cl1 = link.linkClk;
    st_next.cl2 = st_reg.cl1;
    st_next.a1 = link.addr;
    st_next.a2 = st_reg.a1;
    st_next.d1 = link.hostDq;
    st_next.d2 = st_reg.d1;
    st_next.prevClk = clkS;
    st_next.prevRd = rdN;
    st_next.prevWe = weN;
    st_next.ws = 1'b0;
    case (mode)
      pport_pkg::MODE_FIFO: begin
        st_next.dOeN = csN || oeN;
        if (!csN && !rdN) begin
          // address zero is the stream; others return an address/pointer pattern
          st_next.dout = st_reg.a2 == '0 ? fifoData :
            {{(DATA_W-6){1'b0}}, st_reg.a2, st_reg.ptrs[st_reg.a2*4 +: 4]};
        end
        if (!csN && rdN && !st_reg.prevRd) begin
          st_next.ptrs[st_reg.a2*4 +: 4] = st_reg.ptrs[st_reg.a2*4 +: 4] + 4'h1;
          pop = st_reg.a2 == '0 && fifoValid;
        end
      end
      pport_pkg::MODE_AMUX: begin
        st_next.dOeN = csN || oeN;
        if (!csN && !oeN) begin
          st_next.dout = fifoData;
        end
        if (st_reg.active && (csN || oeN)) begin
          pop = fifoValid;
        end
        st_next.active = !csN && !oeN;
        if (!csN && !weN) st_next.wd = st_reg.d2;
        if (!st_reg.prevWe && (weN || csN) && !st_reg.ws) begin
          st_next.ws = 1'b1;
          st_next.prevWe = 1'b1;
        end
        if (csN) st_next.prevWe = 1'b1;
      end
      pport_pkg::MODE_SYNC: begin
        if (rise) begin
          if (csN || oeN) begin
            st_next.lat = shortLatency ? pport_pkg::LAT_SHORT : pport_pkg::LAT_LONG;
            st_next.rdy = 1'b0;
            st_next.dOeN = 1'b1;
            st_next.left = 9'h001 << burstLog;
          end else if (st_reg.lat > 2'h1) begin
            st_next.lat = st_reg.lat - 2'h1;
            st_next.dOeN = 1'b0;
          end else if (st_reg.left != 9'h000) begin
            st_next.rdy = 1'b1;
            st_next.dout = fifoData;
            pop = fifoValid;
            st_next.left = st_reg.left - 9'h001;
            st_next.dOeN = 1'b0;
            st_next.lat = 2'h0;
          end else begin
            st_next.rdy = 1'b0;
          end
        end
      end
      default: st_next.dOeN = 1'b1;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.s1 <= 2'h3;
      st_reg.s2 <= 2'h3;
      st_reg.s3 <= 2'h3;
      st_reg.s4 <= 2'h3;
      st_reg.prevRd <= 1'b1;
      st_reg.prevWe <= 1'b1;
      st_reg.dOeN <= 1'b1;
      st_reg.lat <= pport_pkg::LAT_LONG;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// ==== verilog/pport_host.sv ====
`timescale 1ns/1ps
module pport_host (
  input wire logic mclk,
  input wire logic sys_rst,
  pport_if.host link,
  input wire logic [1:0] mode,
  input wire logic start,
  input wire logic write,
  input wire logic [pport_pkg::ADDR_W-1:0] addr,
  input wire logic [pport_pkg::DATA_W-1:0] wdata,
  input wire logic [8:0] words,
  output logic busy,
  output logic [pport_pkg::DATA_W-1:0] rdata,
  output logic rvalid
);
  typedef enum logic [2:0] {IDLE, ARM, SEL, STROBE, HOLD, DONE} phase_e;
  typedef struct packed {
    phase_e ph;
    logic [4:0] div;
    logic clk;
    logic csN, oeN, rdN, weN, avN, dOeN;
    logic [pport_pkg::ADDR_W-1:0] a;
    logic [pport_pkg::DATA_W-1:0] d, rd;
    logic [pport_pkg::ADDR_W-1:0] reqA;
    logic [pport_pkg::DATA_W-1:0] reqD;
    logic rv;
    logic [8:0] left;
    logic wr;
    logic r1, r2;
  } state_s;
  state_s st_reg, st_next;
  logic edgeRise;
  assign edgeRise = st_reg.div == 5'(pport_pkg::LINK_DIV - 1) && !st_reg.clk;
  assign link.linkClk = st_reg.clk;
  assign link.csN = st_reg.csN;
  assign link.oeN = st_reg.oeN;
  assign link.rdN = st_reg.rdN;
  assign link.weN = st_reg.weN;
  assign link.addressValidN = st_reg.avN;
  assign link.addr = st_reg.a;
  assign link.hostDq = st_reg.d;
  assign link.hostDqOeN = st_reg.dOeN;
  assign busy = st_reg.ph != IDLE;
  assign rdata = st_reg.rd;
  assign rvalid = st_reg.rv;
  always_comb begin
    st_next = st_reg;
    st_next.rv = 1'b0;
    st_next.r1 = link.ready;
    st_next.r2 = st_reg.r1;
    st_next.div = st_reg.div == 5'(pport_pkg::LINK_DIV - 1) ? 5'h00 : st_reg.div + 5'h01;
    if (st_reg.div == 5'(pport_pkg::LINK_DIV - 1)) st_next.clk = !st_reg.clk;
    if (edgeRise) begin
      case (st_reg.ph)
        ARM: begin
          st_next.a = st_reg.reqA;
          st_next.csN = 1'b0;
          st_next.avN = 1'b0;
          st_next.d = st_reg.reqD;
          st_next.ph = SEL;
        end
        SEL: begin
          st_next.avN = 1'b1;
          if (st_reg.wr) begin
            st_next.weN = 1'b0;
            st_next.dOeN = 1'b0;
          end else begin
            st_next.oeN = 1'b0;
            st_next.rdN = mode == pport_pkg::MODE_SYNC;
          end
          st_next.ph = STROBE;
        end
        STROBE: begin
          if (st_reg.wr || mode != pport_pkg::MODE_SYNC) begin
            st_next.rd = link.devDq;
            st_next.rv = !st_reg.wr;
            st_next.rdN = 1'b1;
            st_next.oeN = 1'b1;
            st_next.weN = 1'b1;
            st_next.ph = HOLD;
          end else if (st_reg.r2) begin
            st_next.rd = link.devDq;
            st_next.rv = 1'b1;
            st_next.left = st_reg.left - 9'h001;
            if (st_reg.left == 9'h001) st_next.ph = HOLD;
          end
        end
        HOLD: begin
          st_next.oeN = 1'b1;
          st_next.dOeN = 1'b1;
          st_next.csN = 1'b1;
          st_next.ph = DONE;
        end
        default: st_next.ph = IDLE;
      endcase
    end
    // a one-cycle start may fall between link edges, so keep the request
    if (st_reg.ph == IDLE && start) begin
      st_next.reqA = addr;
      st_next.reqD = wdata;
      st_next.wr = write;
      st_next.left = words;
      st_next.ph = ARM;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.csN <= 1'b1;
      st_reg.oeN <= 1'b1;
      st_reg.rdN <= 1'b1;
      st_reg.weN <= 1'b1;
      st_reg.avN <= 1'b1;
      st_reg.dOeN <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// ==== verif/pport_checker.sv ====
`timescale 1ns/1ps
module pport_checker (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic linkClk,
  input wire logic csN,
  input wire logic oeN,
  input wire logic rdN,
  input wire logic [pport_pkg::DATA_W-1:0] devDq,
  input wire logic devDqOeN,
  input wire logic ready,
  input wire logic shortLatency
);
  logic linkPrev_reg;
  logic [7:0] sinceRise_reg;
  // cycles since the sampled link clock last rose
  always_ff @(posedge mclk) begin
    linkPrev_reg <= linkClk;
    if (sys_rst) begin
      sinceRise_reg <= 8'hFF;
    end else if (linkClk && !linkPrev_reg) begin
      sinceRise_reg <= 8'h00;
    end else if (sinceRise_reg != 8'hFF) begin
      sinceRise_reg <= sinceRise_reg + 8'h01;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence burstEnd;
    $fell(ready) ##0 !oeN;
  endsequence
  ready_hold_a: assert property ($rose(ready) |-> ready[*8])
    else $error("ready dropped early");
  data_hold_a: assert property (burstEnd |=> $stable(devDq) until oeN)
    else $error("last word not held");
  oe_wait_a: assert property (burstEnd |-> ##[1:400] oeN)
    else $error("output enable never released");
  ready_latency_a: assert property ($rose(ready) |-> !oeN && (shortLatency ? !$past(oeN, 2) : !$past(oeN, 45)))
    else $error("ready too early");
  ready_edge_a: assert property ($changed(ready) |-> sinceRise_reg < 8'h08)
    else $error("ready off link edge");
  read_end_ce_a: assert property ($rose(csN) |-> ##[1:6] devDqOeN)
    else $error("bus held after chip enable");
  read_end_oe_a: assert property ($rose(oeN) |-> ##[1:6] devDqOeN)
    else $error("bus held after output enable");
  idle_release_a: assert property (csN[*8] |-> devDqOeN)
    else $error("bus driven while idle");
  oe_drive_a: assert property ((!csN && !oeN && !rdN)[*8] |-> !devDqOeN)
    else $error("bus not driven");
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic mclk, sys_rst, shortLatency, srcValid, srcReady, wrStrobe;
  logic start, write, busy, rvalid;
  logic [1:0] mode;
  logic [2:0] burstLog;
  logic [8:0] words;
  logic [15:0] srcData, wrData, rdata, wdata, fifoPtrs;
  logic [pport_pkg::ADDR_W-1:0] addr;
  logic [15:0] rdQ[$], wrQ[$];
  int n_mismatch = 0, tests_run = 0, nGot = 0, nExp = 0;
  pport_if pport_if_i();
  pport_device pport_device_i (.mclk(mclk), .sys_rst(sys_rst), .link(pport_if_i),
    .mode(mode), .shortLatency(shortLatency), .burstLog(burstLog), .srcData(srcData),
    .srcValid(srcValid), .srcReady(srcReady), .wrData(wrData), .wrStrobe(wrStrobe),
    .fifoPtrs(fifoPtrs));
  pport_host pport_host_i (.mclk(mclk), .sys_rst(sys_rst), .link(pport_if_i), .mode(mode),
    .start(start), .write(write), .addr(addr), .wdata(wdata), .words(words), .busy(busy),
    .rdata(rdata), .rvalid(rvalid));
  pport_checker pport_checker_i (.mclk(mclk), .sys_rst(sys_rst),
    .linkClk(pport_if_i.linkClk), .csN(pport_if_i.csN), .oeN(pport_if_i.oeN),
    .rdN(pport_if_i.rdN), .devDq(pport_if_i.devDq), .devDqOeN(pport_if_i.devDqOeN),
    .ready(pport_if_i.ready), .shortLatency(shortLatency));
  always #2.5 mclk = ~mclk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (n_mismatch == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one host transfer; entered at a falling edge
  task automatic op(input logic [1:0] m, input logic w, input logic [8:0] n, input logic lat);
    logic [31:0] r;
    r = $urandom;
    mode = m;
    write = w;
    words = n;
    shortLatency = lat;
    wdata = r[15:0];
    addr = w ? r[16 +: pport_pkg::ADDR_W] : '0;
    if (w)
      wrQ.push_back(r[15:0]);
    else
      nExp += n;
    start = 1'b1;
    @(negedge mclk) start = 1'b0;
    repeat (3) @(negedge mclk);
    while (busy !== 1'b0) @(negedge mclk);
    repeat (60) @(negedge mclk);
  endtask
  // stream source: new word only once the last one was taken
  logic took = 1'b0;
  always @(posedge mclk) begin
    took = !sys_rst && srcValid && srcReady;
    if (took)
      rdQ.push_back(srcData);
  end
  always @(negedge mclk) if (took) srcData <= $urandom;
  always @(posedge mclk) begin
    if (rvalid === 1'b1) begin
      nGot++;
      chk(rdata, rdQ.pop_front());
    end
    if (wrStrobe === 1'b1)
      chk(wrData, wrQ.pop_front());
  end
  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    mclk = 0; sys_rst = 1; mode = 0; start = 0; write = 0; addr = '0; wdata = 0;
    words = 0; shortLatency = 0; burstLog = 3'h2; srcValid = 1; srcData = 0;
    void'($urandom(65));
    repeat (5) @(negedge mclk);
    sys_rst = 0;
    repeat (40) @(negedge mclk);
    chk(16'(srcReady), 16'h0000); // full buffer refuses
    op(pport_pkg::MODE_AMUX, 1, 1, 0);
    op(pport_pkg::MODE_AMUX, 1, 1, 0);
    op(pport_pkg::MODE_FIFO, 0, 1, 0);
    op(pport_pkg::MODE_FIFO, 0, 1, 0);
    chk({12'h000, fifoPtrs[3:0]}, 16'h0002);
    op(pport_pkg::MODE_AMUX, 0, 1, 0);
    op(pport_pkg::MODE_AMUX, 0, 1, 0);
    op(pport_pkg::MODE_SYNC, 0, 4, 0);
    burstLog = 3'h3;
    op(pport_pkg::MODE_SYNC, 0, 8, 1);
    repeat (300) @(negedge mclk);
    chk(16'(nGot), 16'(nExp));
    chk(16'(wrQ.size()), 16'h0000);
    finish_test();
  end
endmodule
